// File: design/cfg_router_defines.vh
`ifndef CFG_ROUTER_DEFINES_VH
`define CFG_ROUTER_DEFINES_VH

// ****************************************
// i/o locations
// ****************************************
`define CCR_LATCH_ADDR      16'h0cf8
`define CCR_WINDOW_ADDR     16'h0cfc

// ****************************************
// address latch layout and reset
// ****************************************
`define CCR_LATCH_RESET     32'h00000000
`define CCR_LATCH_WR_MASK   32'h80fffffc
`define CCR_ENABLE_BIT      31
`define CCR_BUS_HI          23
`define CCR_BUS_LO          16
`define CCR_DEV_HI          15
`define CCR_DEV_LO          11
`define CCR_FUNC_HI         10
`define CCR_FUNC_LO         8
`define CCR_REG_HI          7
`define CCR_REG_LO          2

// ****************************************
// decode constants
// ****************************************
`define CCR_INT_DEV_MASK    32'h0000004f
`define CCR_IGNORED_RDATA   32'hffffffff
`define CCR_TYPE0_CODE      2'h0
`define CCR_TYPE1_CODE      2'h1
`define CCR_FULL_DWORD      4'hf

// ****************************************
// route codes
// ****************************************
`define CCR_RT_INTERNAL     3'h0
`define CCR_RT_IGNORED      3'h1
`define CCR_RT_HUB_TYPE0    3'h2
`define CCR_RT_HUB_TYPE1    3'h3
`define CCR_RT_GFX_TYPE0    3'h4
`define CCR_RT_GFX_TYPE1    3'h5

`endif

// File: design/cfg_route_decoder.v
`timescale 1ns/10ps
`include "cfg_router_defines.vh"

module cfg_route_decoder (
  // latched fields
  input  wire [7:0] bus_num,
  input  wire [4:0] dev_num,
  input  wire [2:0] func_num,
  // graphics bridge bus range
  input  wire [7:0] sec_bus,
  input  wire [7:0] sub_bus,
  // decision
  output reg  [2:0] route
);

  localparam [31:0] INT_MASK = `CCR_INT_DEV_MASK;

  always @* begin
    if (bus_num == 8'h00) begin
      if (INT_MASK[dev_num]) begin
        if (func_num != 3'h0) begin
          route = `CCR_RT_IGNORED;
        end else begin
          route = `CCR_RT_INTERNAL;
        end
      end else begin
        route = `CCR_RT_HUB_TYPE0;
      end
    end else if (bus_num == sec_bus) begin
      route = `CCR_RT_GFX_TYPE0;
    end else if ((bus_num > sec_bus) && (bus_num <= sub_bus)) begin
      route = `CCR_RT_GFX_TYPE1;
    end else begin
      route = `CCR_RT_HUB_TYPE1;
    end
  end

endmodule // cfg_route_decoder

// File: design/cfg_idsel_decoder.v
`timescale 1ns/10ps

module cfg_idsel_decoder (
  // device field
  input  wire [4:0]  dev_num,
  // one-hot select for lines 31:16, all zero for devices 16-31
  output wire [15:0] idsel
);

  genvar i;
  generate
    for (i = 0; i < 16; i = i + 1) begin : g_sel
      assign idsel[i] = ~dev_num[4] & (dev_num[3:0] == i[3:0]);
    end
  endgenerate

endmodule // cfg_idsel_decoder

// File: design/config_cycle_address_router.v
`timescale 1ns/10ps
`include "cfg_router_defines.vh"

module config_cycle_address_router (
  // clock and reset
  input  wire        ref_clk,
  input  wire        arst_n,
  // processor i/o port
  input  wire        io_req,
  input  wire        io_write,
  input  wire [15:0] io_addr,
  input  wire [3:0]  io_be,
  input  wire [31:0] io_wdata,
  output wire        io_ack,
  output wire [31:0] io_rdata,
  // graphics bridge bus range
  input  wire [7:0]  sec_bus,
  input  wire [7:0]  sub_bus,
  // internal function port
  output wire        int_req,
  output wire        int_write,
  output wire [4:0]  int_dev,
  output wire [5:0]  int_reg,
  output wire [3:0]  int_be,
  output wire [31:0] int_wdata,
  input  wire        int_ack,
  input  wire [31:0] int_rdata,
  // hub link request port
  output wire        hub_link_req,
  output wire        hub_link_write,
  output wire        hub_link_cfg,
  output wire [31:0] hub_link_addr,
  output wire [3:0]  hub_link_be,
  output wire [31:0] hub_link_wdata,
  input  wire        hub_link_ack,
  input  wire [31:0] hub_link_rdata,
  // graphics-side bus port
  output wire        gfx_req,
  output wire        gfx_write,
  output wire        gfx_type1,
  output wire [31:0] graphics_addr_data_line,
  output wire [3:0]  gfx_be,
  output wire [31:0] gfx_wdata,
  input  wire        gfx_ack,
  input  wire [31:0] gfx_rdata,
  input  wire        gfx_master_abort,
  // status
  output wire        config_access_enable,
  output wire        gfx_abort_seen
);

  // ****************************************
  // constants and states
  // ****************************************
  localparam [15:0] LATCH_ADDR  = `CCR_LATCH_ADDR;
  localparam [15:0] WINDOW_ADDR = `CCR_WINDOW_ADDR;
  localparam [31:0] WR_MASK     = `CCR_LATCH_WR_MASK;
  localparam [1:0]  S_IDLE      = 2'h0;
  localparam [1:0]  S_ISSUE     = 2'h1;
  localparam [1:0]  S_WAIT      = 2'h2;
  localparam [1:0]  S_DONE      = 2'h3;
  localparam [1:0]  TGT_INT     = 2'h0;
  localparam [1:0]  TGT_HUB     = 2'h1;
  localparam [1:0]  TGT_GFX     = 2'h2;

  // ****************************************
  // declarations
  // ****************************************
  reg  [31:0] latch_ff;
  reg  [1:0]  state_ff;
  reg  [1:0]  nxt_state;
  reg  [1:0]  tgt_ff;
  reg  [31:0] rdata_ff;
  reg         ack_ff;
  reg         int_req_ff;
  reg         hub_req_ff;
  reg         gfx_req_ff;
  reg         write_ff;
  reg         hub_cfg_ff;
  reg         gfx_type1_ff;
  reg  [31:0] addr_ff;
  reg  [3:0]  be_ff;
  reg  [31:0] wdata_ff;
  reg  [4:0]  int_dev_ff;
  reg  [5:0]  int_reg_ff;
  reg         abort_ff;
  wire [2:0]  route;
  wire [15:0] idsel;
  wire        hit_latch;
  wire        hit_window;
  wire        latch_claim;
  wire        cfg_window;
  wire        take;
  wire        tgt_ack;
  wire [31:0] tgt_rdata;
  wire [7:0]  bus_num;
  wire [4:0]  dev_num;
  wire [2:0]  func_num;
  wire [5:0]  reg_num;

  // ****************************************
  // access decode
  // ****************************************
  assign bus_num  = latch_ff[`CCR_BUS_HI:`CCR_BUS_LO];
  assign dev_num  = latch_ff[`CCR_DEV_HI:`CCR_DEV_LO];
  assign func_num = latch_ff[`CCR_FUNC_HI:`CCR_FUNC_LO];
  assign reg_num  = latch_ff[`CCR_REG_HI:`CCR_REG_LO];
  assign take       = io_req & (state_ff == S_IDLE);
  assign hit_latch  = (io_addr[15:2] == LATCH_ADDR[15:2]);
  assign hit_window = (io_addr[15:2] == WINDOW_ADDR[15:2]);
  assign latch_claim = hit_latch & (io_be == `CCR_FULL_DWORD);
  assign cfg_window  = hit_window & latch_ff[`CCR_ENABLE_BIT];
  assign config_access_enable = latch_ff[`CCR_ENABLE_BIT];

  cfg_route_decoder u_route (
    .bus_num  (bus_num),
    .dev_num  (dev_num),
    .func_num (func_num),
    .sec_bus  (sec_bus),
    .sub_bus  (sub_bus),
    .route    (route)
  );

  cfg_idsel_decoder u_idsel (
    .dev_num (dev_num),
    .idsel   (idsel)
  );

  // ****************************************
  // address latch
  // ****************************************
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      latch_ff <= `CCR_LATCH_RESET;
    end else if (take & io_write & latch_claim) begin
      latch_ff <= io_wdata & WR_MASK;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always @* begin
    case (state_ff)
      S_IDLE: begin
        if (!io_req) begin
          nxt_state = S_IDLE;
        end else if (latch_claim) begin
          nxt_state = S_DONE;
        end else if (cfg_window && (route == `CCR_RT_IGNORED)) begin
          nxt_state = S_DONE;
        end else begin
          nxt_state = S_ISSUE;
        end
      end
      S_ISSUE: begin
        nxt_state = S_WAIT;
      end
      S_WAIT: begin
        nxt_state = tgt_ack ? S_DONE : S_WAIT;
      end
      S_DONE: begin
        nxt_state = S_IDLE;
      end
      default: begin
        nxt_state = S_IDLE;
      end
    endcase
  end

  assign tgt_ack   = (tgt_ff == TGT_INT) ? int_ack :
                     (tgt_ff == TGT_HUB) ? hub_link_ack : gfx_ack;
  assign tgt_rdata = (tgt_ff == TGT_INT) ? int_rdata :
                     (tgt_ff == TGT_HUB) ? hub_link_rdata : gfx_rdata;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff     <= S_IDLE;
      tgt_ff       <= TGT_HUB;
      rdata_ff     <= 32'h00000000;
      ack_ff       <= 1'b0;
      write_ff     <= 1'b0;
      hub_cfg_ff   <= 1'b0;
      gfx_type1_ff <= 1'b0;
      addr_ff      <= 32'h00000000;
      be_ff        <= 4'h0;
      wdata_ff     <= 32'h00000000;
      int_dev_ff   <= 5'h00;
      int_reg_ff   <= 6'h00;
    end else begin
      state_ff <= nxt_state;
      ack_ff   <= (nxt_state == S_DONE);
      if (take) begin
        write_ff   <= io_write;
        be_ff      <= io_be;
        wdata_ff   <= io_wdata;
        int_dev_ff <= dev_num;
        int_reg_ff <= reg_num;
        hub_cfg_ff <= 1'b0;
        tgt_ff     <= TGT_HUB;
        if (latch_claim) begin
          rdata_ff <= latch_ff;
        end else if (cfg_window) begin
          case (route)
            `CCR_RT_INTERNAL: begin
              tgt_ff <= TGT_INT;
            end
            `CCR_RT_IGNORED: begin
              rdata_ff <= `CCR_IGNORED_RDATA;
            end
            `CCR_RT_HUB_TYPE0: begin
              hub_cfg_ff <= 1'b1;
              addr_ff    <= {latch_ff[31:2], `CCR_TYPE0_CODE};
            end
            `CCR_RT_GFX_TYPE0: begin
              tgt_ff       <= TGT_GFX;
              gfx_type1_ff <= 1'b0;
              addr_ff      <= {idsel, 5'h00, func_num, reg_num, `CCR_TYPE0_CODE};
            end
            `CCR_RT_GFX_TYPE1: begin
              tgt_ff       <= TGT_GFX;
              gfx_type1_ff <= 1'b1;
              addr_ff      <= {8'h00, bus_num, dev_num, func_num, reg_num, `CCR_TYPE1_CODE};
            end
            default: begin
              hub_cfg_ff <= 1'b1;
              addr_ff    <= {latch_ff[31:2], `CCR_TYPE1_CODE};
            end
          endcase
        end else begin
          addr_ff <= {16'h0000, io_addr};
        end
      end else if ((state_ff == S_WAIT) && tgt_ack) begin
        rdata_ff <= tgt_rdata;
      end
    end
  end

  // ****************************************
  // request strobes
  // ****************************************
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      int_req_ff <= 1'b0;
      hub_req_ff <= 1'b0;
      gfx_req_ff <= 1'b0;
    end else begin
      int_req_ff <= (state_ff == S_ISSUE) && (tgt_ff == TGT_INT);
      hub_req_ff <= (state_ff == S_ISSUE) && (tgt_ff == TGT_HUB);
      gfx_req_ff <= (state_ff == S_ISSUE) && (tgt_ff == TGT_GFX);
    end
  end

  // ****************************************
  // graphics abort tracking
  // ****************************************
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      abort_ff <= 1'b0;
    end else if ((state_ff == S_WAIT) && (tgt_ff == TGT_GFX) && gfx_ack) begin
      abort_ff <= gfx_master_abort;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign io_ack         = ack_ff;
  assign io_rdata       = rdata_ff;
  assign int_req        = int_req_ff;
  assign int_write      = write_ff;
  assign int_dev        = int_dev_ff;
  assign int_reg        = int_reg_ff;
  assign int_be         = be_ff;
  assign int_wdata      = wdata_ff;
  assign hub_link_req   = hub_req_ff;
  assign hub_link_write = write_ff;
  assign hub_link_cfg   = hub_cfg_ff;
  // function and register bits in address
  assign hub_link_addr  = addr_ff;
  assign hub_link_be    = be_ff;
  assign hub_link_wdata = wdata_ff;
  assign gfx_req        = gfx_req_ff;
  assign gfx_write      = write_ff;
  assign gfx_type1      = gfx_type1_ff;
  assign graphics_addr_data_line = addr_ff;
  assign gfx_be         = be_ff;
  assign gfx_wdata      = wdata_ff;
  assign gfx_abort_seen = abort_ff;

endmodule // config_cycle_address_router

// File: verification/cfg_target_model.sv
`timescale 1ns/10ps
module cfg_target_model #(
  parameter logic [31:0] VAL = 32'h0
) (
  // clock, reset, pacing
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        slow,
  // request and answer
  input  wire logic        req,
  output logic             ack,
  output logic      [31:0] rdata
);
  logic [2:0] wait_ff;
  // released data lines show the inverse of the answer
  assign rdata = ack ? VAL : ~VAL;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_ff <= 3'h0;
      ack <= 1'b0;
    end else begin
      ack <= (wait_ff == 3'h1);
      if (req) begin
        wait_ff <= slow ? 3'h4 : 3'h1;
      end else if (wait_ff != 3'h0) begin
        wait_ff <= wait_ff - 3'h1;
      end
    end
  end
endmodule // cfg_target_model

// File: verification/config_cycle_address_router_monitor.sv
`timescale 1ns/10ps
module config_cycle_address_router_monitor (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        arst_n,
  // processor i/o port
  input wire logic        io_req,
  input wire logic        io_write,
  input wire logic [15:0] io_addr,
  input wire logic [3:0]  io_be,
  input wire logic [31:0] io_wdata,
  input wire logic        io_ack,
  input wire logic [31:0] io_rdata,
  // far-side requests and answers
  input wire logic        int_req,
  input wire logic        int_ack,
  input wire logic        hub_link_req,
  input wire logic        hub_link_cfg,
  input wire logic [31:0] hub_link_addr,
  input wire logic        hub_link_ack,
  input wire logic        gfx_req,
  input wire logic        gfx_type1,
  input wire logic [31:0] graphics_addr_data_line,
  input wire logic        gfx_ack,
  input wire logic        gfx_master_abort,
  // status
  input wire logic        gfx_abort_seen,
  input wire logic        config_access_enable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire lat_take = io_req && io_addr == 16'h0cf8 && io_be == 4'hf;
  wire quiet    = !hub_link_req && !gfx_req && !int_req;
  sequence s_latch_done;
    ##1 (quiet && io_ack) ##1 (quiet && !io_ack);
  endsequence
  sequence s_plain_fwd;
    ##2 (hub_link_req && !hub_link_cfg && hub_link_addr == {16'h0, $past(io_addr, 2)});
  endsequence
  property p_latch_done; lat_take |-> s_latch_done; endproperty
  property p_partial_fwd; io_req && io_addr == 16'h0cf8 && io_be != 4'hf |-> s_plain_fwd; endproperty
  property p_enable_bit; lat_take && io_write |-> ##2 config_access_enable == $past(io_wdata[31], 2); endproperty
  property p_reserved; lat_take && !io_write |-> ##2 io_rdata[30:24] == 7'h0 && io_rdata[1:0] == 2'h0; endproperty
  property p_disabled_fwd; io_req && io_addr == 16'h0cfc && !config_access_enable |-> s_plain_fwd; endproperty
  property p_idsel; gfx_req && !gfx_type1 |-> $onehot0(graphics_addr_data_line[31:16]); endproperty
  property p_gfx_t1; gfx_req && gfx_type1 |-> graphics_addr_data_line[31:24] == 8'h0 && graphics_addr_data_line[1:0] == 2'h1;
  endproperty
  property p_hub_t1; hub_link_req && hub_link_cfg && hub_link_addr[23:16] != 8'h0 |-> hub_link_addr[1:0] == 2'h1;
  endproperty
  property p_answer; hub_link_ack || gfx_ack || int_ack |=> io_ack; endproperty
  property p_abort; gfx_ack |=> gfx_abort_seen == $past(gfx_master_abort); endproperty
  a_p_latch_done: assert property (p_latch_done) else $error("latch access not local in 1 cycle");
  a_p_partial_fwd: assert property (p_partial_fwd) else $error("partial latch access not forwarded");
  a_p_enable_bit: assert property (p_enable_bit) else $error("enable does not follow bit 31");
  a_p_reserved: assert property (p_reserved) else $error("reserved latch bits read nonzero");
  a_p_disabled_fwd: assert property (p_disabled_fwd) else $error("disabled window not plain i/o");
  a_p_idsel: assert property (p_idsel) else $error("device select not one-hot");
  a_p_gfx_t1: assert property (p_gfx_t1) else $error("graphics type 1 address wrong");
  a_p_hub_t1: assert property (p_hub_t1) else $error("hub type 1 code wrong");
  a_p_answer: assert property (p_answer) else $error("no answer after target ack");
  a_p_abort: assert property (p_abort) else $error("abort status not kept");
endmodule // config_cycle_address_router_monitor
bind config_cycle_address_router config_cycle_address_router_monitor u_config_cycle_address_router_monitor (.*);

// File: verification/config_cycle_address_router_tb.sv
`timescale 1ns/10ps
module config_cycle_address_router_tb;
  localparam logic [31:0] IV = 32'h1e1e0001, HV = 32'h2d2d0002, GV = 32'h3c3c0003;
  logic        ref_clk, arst_n, io_req, io_write, slow;
  logic [15:0] io_addr;
  logic [3:0]  io_be;
  logic [31:0] io_wdata, rd, lat, exp_a;
  logic [7:0]  sec_bus, sub_bus;
  wire         io_ack, int_req, int_ack, hub_link_req, hub_link_write, hub_link_cfg, hub_link_ack;
  wire         gfx_req, gfx_type1, gfx_ack, gfx_master_abort, config_access_enable, gfx_abort_seen;
  wire         int_write, gfx_write;
  wire [3:0]   int_be, hub_link_be, gfx_be;
  wire [31:0]  int_wdata, gfx_wdata;
  wire [4:0]   int_dev;
  wire [5:0]   int_reg;
  wire [31:0]  io_rdata, int_rdata, hub_link_addr, hub_link_wdata, hub_link_rdata, graphics_addr_data_line, gfx_rdata;
  int          n_fail, compares, i;
  // ****************************************
  // design and far-side targets
  // ****************************************
  config_cycle_address_router u_config_cycle_address_router (.*);
  cfg_target_model #(.VAL(IV)) u_cfg_target_model_int (.req(int_req), .ack(int_ack), .rdata(int_rdata), .*);
  cfg_target_model #(.VAL(HV)) u_cfg_target_model_hub (.req(hub_link_req), .ack(hub_link_ack), .rdata(hub_link_rdata), .*);
  cfg_target_model #(.VAL(GV)) u_cfg_target_model_gfx (.req(gfx_req), .ack(gfx_ack), .rdata(gfx_rdata), .*);
  // type 0 with no device select finds no target
  assign gfx_master_abort = gfx_ack && !gfx_type1 && graphics_addr_data_line[31:16] == 16'h0;
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (n_fail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic io(input logic w, input logic [15:0] a, input logic [3:0] be, input logic [31:0] wd);
    int k;
    @(posedge ref_clk);
    io_req <= 1'b1;
    io_write <= w;
    io_addr <= a;
    io_be <= be;
    io_wdata <= wd;
    @(posedge ref_clk);
    io_req <= 1'b0;
    k = 0;
    #1;
    while (io_ack !== 1'b1) begin
      if (k == 20) begin
        n_fail++;
        close_out();
      end
      @(posedge ref_clk);
      #1;
      k++;
    end
    rd = io_rdata;
  endtask
  task automatic win(input logic [31:0] l, input logic w, input logic [31:0] wd);
    io(1'b1, 16'h0cf8, 4'hf, l);
    io(w, 16'h0cfc, 4'hf, wd);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    io_req = 0; io_write = 0; io_addr = 0; io_be = 0; io_wdata = 0; slow = 0;
    sec_bus = 8'h05; sub_bus = 8'h09; n_fail = 0; compares = 0; arst_n = 0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    io(1'b0, 16'h0cf8, 4'hf, 32'h0);
    chk(rd, 32'h0);
    io(1'b1, 16'h0cf8, 4'hf, 32'hffffffff);
    chk(config_access_enable, 1'b1);
    io(1'b1, 16'h0cf8, 4'h3, 32'h0);
    chk({hub_link_cfg, hub_link_be, hub_link_addr}, {1'b0, 4'h3, 32'h0cf8});
    io(1'b0, 16'h0cf8, 4'hf, 32'h0);
    chk(rd, 32'h80fffffc);
    for (i = 0; i < 8; i++) begin
      slow <= i[0];
      lat = {1'b1, 15'h0, i[4:0], 3'h0, 6'h0a, 2'h0};
      win(lat, i[1], 32'h6b6b0000 + i);
      if (i inside {0, 1, 2, 3, 6}) chk({int_dev, int_reg, rd}, {i[4:0], 6'h0a, IV});
      if (i inside {0, 1, 2, 3, 6}) chk({int_write, int_be, int_wdata}, {i[1], 4'hf, 32'h6b6b0000 + i});
      else chk({hub_link_cfg, hub_link_write, hub_link_be, hub_link_addr, rd}, {1'b1, i[1], 4'hf, lat, HV});
    end
    win({1'b1, 15'h0, 5'h01, 3'h2, 8'h0}, 1'b0, 32'h0);
    chk(rd, 32'hffffffff);
    for (i = 0; i < 18; i++) begin
      slow <= i[0];
      win({1'b1, 7'h0, 8'h05, i[4:0], 3'h3, 6'h11, 2'h0}, 1'b0, 32'h0);
      exp_a = {(i < 16) ? 16'h1 << i : 16'h0, 5'h0, 3'h3, 6'h11, 2'h0};
      chk({gfx_type1, gfx_write, gfx_be, graphics_addr_data_line}, {1'b0, 1'b0, 4'hf, exp_a});
      chk(gfx_abort_seen, i > 15);
      if (i < 16) chk(rd, GV);
    end
    for (i = 6; i < 10; i += 3) begin
      win({1'b1, 7'h0, i[7:0], 5'h1f, 3'h7, 6'h3f, 2'h0}, 1'b1, 32'h7c7c0000 + i);
      chk({gfx_type1, gfx_write, rd}, {2'h3, GV});
      chk(graphics_addr_data_line, {8'h0, i[7:0], 5'h1f, 3'h7, 6'h3f, 2'h1});
      chk(gfx_wdata, 32'h7c7c0000 + i);
    end
    for (i = 4; i < 11; i += 6) begin
      lat = {1'b1, 7'h0, i[7:0], 5'h02, 3'h1, 6'h05, 2'h0};
      win(lat, 1'b1, 32'h5a5a0000 + i);
      chk({hub_link_cfg, hub_link_write, hub_link_addr}, {2'h3, lat | 32'h1});
      chk(hub_link_wdata, 32'h5a5a0000 + i);
    end
    io(1'b1, 16'h0cf8, 4'hf, 32'h00050000);
    io(1'b0, 16'h0cfc, 4'hf, 32'h0);
    chk({config_access_enable, hub_link_cfg, hub_link_addr, rd}, {2'h0, 32'h0cfc, HV});
    close_out();
  end
endmodule // config_cycle_address_router_tb
